// file: src/tcprc_pkg.sv
// package: types, timing constants and decode helpers for the role block
// Overview of operation
// RQ1 - role strap: high gives source-only, low sink-only, floating dual-role
// RQ2 - role strap is sampled once after reset and held until next reset
// RQ3 - host may also select source-only by writing the role select port
// RQ4 - as source, both CC lines carry pull-ups at all times
// RQ5 - source starts at default current; host writes change the pull-up level
// RQ6 - in GPIO control style a source advertises default current only
// RQ7 - as sink, both CC lines carry pull-downs at all times
// RQ8 - sink debounces CC and waits for debounced VBUS before attaching
// RQ9 - sink captures partner current once on attach and reports it
// RQ10 - host issues soft reset periodically to refresh the detected current
// RQ11 - dual-role toggles between source and sink, each behaving per its role
// RQ12 - advertise level holds default, medium or high; default after reset
// RQ13 - audio and debug accessory status readable in every role
// RQ14 - audio adapter recognised only when both lines show Ra
// RQ15 - GPIO style: audio pin pulled low while audio accessory attached
// RQ16 - no charge-through debug accessory in dual-role or sink-only
// RQ17 - control strap: floating gives GPIO style, high or low gives I2C
// RQ18 - all pins are open-drain: pull low or release, never drive high
// RQ19 - GPIO current pins: HH unattached, HL default, LH medium, LL high
// RQ20 - interrupt pulled low on status update, held until host clears it
// RQ21 - role override accepted only while unattached, ignored when attached
// RQ22 - in I2C style the current pins carry the bus, no GPIO code
package tcprc_pkg;
    typedef enum logic [1:0] {
        STRAP_LOW = 2'h0, STRAP_HIGH = 2'h1, STRAP_FLOAT = 2'h2
    } tcprc_strap_t;
    typedef enum logic [1:0] {
        ROLE_SRC = 2'h0, ROLE_SNK = 2'h1, ROLE_DRP = 2'h2
    } tcprc_role_t;
    typedef enum logic [1:0] {
        CUR_NONE = 2'h0, CUR_DEF = 2'h1, CUR_MED = 2'h2, CUR_HIGH = 2'h3
    } tcprc_cur_t;
    // line as seen by the analog comparators
    typedef enum logic [2:0] {
        CC_OPEN = 3'h0, CC_RA = 3'h1, CC_RD = 3'h2,
        CC_RP_DEF = 3'h3, CC_RP_MED = 3'h4, CC_RP_HIGH = 3'h5
    } tcprc_cc_t;
    typedef enum logic [7:0] {
        ST_UNSNK = 8'h01, ST_UNSRC = 8'h02, ST_WSNK = 8'h04,
        ST_WSRC = 8'h08, ST_ASNK = 8'h10, ST_ASRC = 8'h20,
        ST_AUDIO = 8'h40, ST_DEBUG = 8'h80
    } tcprc_state_t;

    localparam int CNT_W = 23;
    localparam int unsigned CLK_HZ = 32'h017D_7840;   // 25 MHz
    localparam int unsigned MS_PER_S = 32'h0000_03E8;
    localparam int unsigned PCT_FULL = 32'h0000_0064;
    localparam int unsigned T_CC_DB_MS = 32'h0000_00A8;   // 168 ms
    localparam int unsigned T_VBUS_DB_MS = 32'h0000_0002; // 2 ms
    localparam int unsigned T_DRP_MS = 32'h0000_004B;     // 75 ms
    localparam int unsigned DRP_DUTY_PCT = 32'h0000_001E; // 30 %
    localparam int unsigned CC_DB_CYC = T_CC_DB_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned VBUS_DB_CYC = T_VBUS_DB_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned DRP_CYC = T_DRP_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned DRP_SRC_CYC = DRP_CYC * DRP_DUTY_PCT / PCT_FULL;
    localparam tcprc_cur_t ADV_RESET = CUR_DEF;

    function automatic logic is_rp(input tcprc_cc_t c);
        return c == CC_RP_DEF || c == CC_RP_MED || c == CC_RP_HIGH;
    endfunction

    function automatic tcprc_cur_t sink_cur(input tcprc_cc_t a,
                                            input tcprc_cc_t b);
        tcprc_cc_t c;
        c = is_rp(a) ? a : b;
        case (c)
            CC_RP_DEF: return CUR_DEF;
            CC_RP_MED: return CUR_MED;
            CC_RP_HIGH: return CUR_HIGH;
            default: return CUR_NONE;
        endcase
    endfunction

    function automatic tcprc_role_t role_of(input tcprc_strap_t s);
        case (s)
            STRAP_HIGH: return ROLE_SRC;
            STRAP_LOW: return ROLE_SNK;
            default: return ROLE_DRP;
        endcase
    endfunction

    function automatic logic is_attached(input tcprc_state_t s);
        return s == ST_ASNK || s == ST_ASRC || s == ST_AUDIO || s == ST_DEBUG;
    endfunction

    function automatic logic is_src_side(input tcprc_state_t s);
        return s != ST_UNSNK && s != ST_WSNK && s != ST_ASNK;
    endfunction

    // {pin a pulled low, pin b pulled low}
    function automatic logic [1:0] gpio_code(input tcprc_cur_t c);
        case (c)
            CUR_DEF: return 2'h1;
            CUR_MED: return 2'h2;
            CUR_HIGH: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction
endpackage

// file: src/tcprc_strap.sv
// tri-level strap capture, taken once after reset release
`timescale 1ns/1ps
`default_nettype none
module tcprc_strap (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic tie_high,
    input wire logic tie_low,
    output var tcprc_pkg::tcprc_strap_t code,
    output logic valid
);
    import tcprc_pkg::*;

    // caught on the first edge after release, never under reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            code <= STRAP_FLOAT;
            valid <= 1'b0;
        end else if (!valid) begin
            valid <= 1'b1;
            if (tie_high)
                code <= STRAP_HIGH;
            else if (tie_low)
                code <= STRAP_LOW;
            else
                code <= STRAP_FLOAT;
        end
    end
endmodule
`default_nettype wire

// file: src/tcprc_debounce.sv
// debounce: output follows input once it has held still for CYC cycles
`timescale 1ns/1ps
`default_nettype none
module tcprc_debounce #(
    parameter int W = 1,
    parameter int unsigned CYC = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] level_out,
    output logic settled
);
    import tcprc_pkg::*;

    logic [W-1:0] last_reg;
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            last_reg <= '0;
            cnt_reg <= '0;
            level_out <= '0;
            settled <= 1'b0;
        end else if (level_in != last_reg) begin
            last_reg <= level_in;
            cnt_reg <= '0;
            settled <= 1'b0;
        end else if (cnt_reg == CNT_W'(CYC - 1)) begin
            level_out <= last_reg;
            settled <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: src/tcprc_port_ctrl.sv
// port role, CC termination and current-mode control
`timescale 1ns/1ps
`default_nettype none
module tcprc_port_ctrl #(
    parameter int unsigned CC_DB_CYCLES = tcprc_pkg::CC_DB_CYC,
    parameter int unsigned VBUS_DB_CYCLES = tcprc_pkg::VBUS_DB_CYC,
    parameter int unsigned DRP_CYCLES = tcprc_pkg::DRP_CYC,
    parameter int unsigned DRP_SRC_CYCLES = tcprc_pkg::DRP_SRC_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic port_strap_high,
    input wire logic port_strap_low,
    input wire logic addr_strap_high,
    input wire logic addr_strap_low,
    input wire tcprc_pkg::tcprc_cc_t cc1_sense,
    input wire tcprc_pkg::tcprc_cc_t cc2_sense,
    input wire logic vbus_det,
    input wire logic mode_sel_wr,
    input wire tcprc_pkg::tcprc_role_t mode_sel_role,
    input wire logic adv_wr,
    input wire tcprc_pkg::tcprc_cur_t adv_level,
    input wire logic soft_reset,
    input wire logic int_clear,
    output logic cc_pullup_en,
    output logic cc_pulldown_en,
    output var tcprc_pkg::tcprc_cur_t cc_rp_level,
    output logic current_code_out_a_oe,
    output logic current_code_out_b_oe,
    output logic audio_accessory_out_oe,
    output var tcprc_pkg::tcprc_role_t role_out,
    output logic i2c_mode,
    output logic attached,
    output var tcprc_pkg::tcprc_cur_t cur_detect,
    output logic audio_det,
    output logic debug_det,
    output logic int_status
);
    import tcprc_pkg::*;

    tcprc_state_t state_reg, state_next;
    tcprc_strap_t port_code, ctrl_code;
    tcprc_cur_t adv_reg;
    logic port_valid, ctrl_valid, role_loaded_reg;
    logic cc_settled;
    logic [0:0] vbus_lvl;
    logic vbus_settled, vbus_ok;
    logic rp_seen, rd_any, rd_both, ra_both, src_partner;
    logic unatt, drp_src_phase, debug_ok;
    logic cap_evt, refresh_evt, status_evt;
    logic [CNT_W-1:0] drp_cnt_reg;

    ////////////////////////////////////////////////////////////////////
    // straps and line conditioning

    tcprc_strap u_port_strap (
        .clk_sys(clk_sys),
        .srst(srst),
        .tie_high(port_strap_high),
        .tie_low(port_strap_low),
        .code(port_code),
        .valid(port_valid)
    );

    tcprc_strap u_ctrl_strap (
        .clk_sys(clk_sys),
        .srst(srst),
        .tie_high(addr_strap_high),
        .tie_low(addr_strap_low),
        .code(ctrl_code),
        .valid(ctrl_valid)
    );

    tcprc_debounce #(.W(6), .CYC(CC_DB_CYCLES)) u_cc_db (
        .clk_sys(clk_sys),
        .srst(srst),
        .level_in({cc1_sense, cc2_sense}),
        .level_out(),
        .settled(cc_settled)
    );

    tcprc_debounce #(.W(1), .CYC(VBUS_DB_CYCLES)) u_vbus_db (
        .clk_sys(clk_sys),
        .srst(srst),
        .level_in(vbus_det),
        .level_out(vbus_lvl),
        .settled(vbus_settled)
    );

    // the debounced level only moves once settled, so it alone decides
    assign vbus_ok = vbus_lvl[0];
    assign rp_seen = is_rp(cc1_sense) || is_rp(cc2_sense);
    assign rd_any = cc1_sense == CC_RD || cc2_sense == CC_RD;
    assign rd_both = cc1_sense == CC_RD && cc2_sense == CC_RD;
    assign ra_both = cc1_sense == CC_RA && cc2_sense == CC_RA; // RQ14
    assign src_partner = rd_any || ra_both;
    assign unatt = state_reg == ST_UNSNK || state_reg == ST_UNSRC;
    // a debug accessory that powers vbus is charge-through
    assign debug_ok = role_out == ROLE_SRC || !vbus_ok; // RQ16
    assign drp_src_phase = drp_cnt_reg < CNT_W'(DRP_SRC_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // role and control style

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            role_loaded_reg <= 1'b0;
            role_out <= ROLE_SNK;
            i2c_mode <= 1'b0;
        end else if (!role_loaded_reg) begin
            if (port_valid && ctrl_valid) begin
                role_loaded_reg <= 1'b1;
                role_out <= role_of(port_code); // RQ1 RQ2
                i2c_mode <= ctrl_code != STRAP_FLOAT; // RQ17
            end
        end else if (mode_sel_wr && i2c_mode && unatt &&
                     mode_sel_role != tcprc_role_t'(2'h3)) begin
            role_out <= mode_sel_role; // RQ3 RQ21
        end
    end

    // toggle timer runs only while hunting for a partner as dual-role
    always_ff @(posedge clk_sys) begin
        if (srst || role_out != ROLE_DRP || !unatt)
            drp_cnt_reg <= '0;
        else if (drp_cnt_reg == CNT_W'(DRP_CYCLES - 1))
            drp_cnt_reg <= '0;
        else
            drp_cnt_reg <= drp_cnt_reg + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // attach state machine

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_UNSNK: begin
                if (!role_loaded_reg)
                    state_next = ST_UNSNK;
                else if (role_out == ROLE_SRC)
                    state_next = ST_UNSRC;
                else if (rp_seen)
                    state_next = ST_WSNK;
                else if (role_out == ROLE_DRP && drp_src_phase)
                    state_next = ST_UNSRC; // RQ11
            end
            ST_UNSRC: begin
                if (role_out == ROLE_SNK)
                    state_next = ST_UNSNK;
                else if (src_partner)
                    state_next = ST_WSRC;
                else if (role_out == ROLE_DRP && !drp_src_phase)
                    state_next = ST_UNSNK; // RQ11
            end
            ST_WSNK: begin
                if (!rp_seen)
                    state_next = ST_UNSNK;
                else if (cc_settled && vbus_ok)
                    state_next = ST_ASNK; // RQ8
            end
            ST_WSRC: begin
                if (!src_partner)
                    state_next = ST_UNSRC;
                else if (cc_settled) begin
                    if (ra_both)
                        state_next = ST_AUDIO;
                    else if (rd_both)
                        state_next = debug_ok ? ST_DEBUG : ST_WSRC; // RQ16
                    else
                        state_next = ST_ASRC;
                end
            end
            ST_ASNK: begin
                if (!vbus_ok)
                    state_next = ST_UNSNK;
            end
            ST_ASRC: begin
                if (!rd_any)
                    state_next = ST_UNSRC;
            end
            ST_AUDIO: begin
                if (!ra_both)
                    state_next = ST_UNSRC;
            end
            ST_DEBUG: begin
                if (!rd_both)
                    state_next = ST_UNSRC;
            end
            default: state_next = ST_UNSNK;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst)
            state_reg <= ST_UNSNK;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////
    // terminations and advertised current

    // reset comes up as an unattached sink, the dead-battery default
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cc_pullup_en <= 1'b0;
            cc_pulldown_en <= 1'b1;
        end else begin
            cc_pullup_en <= is_src_side(state_next); // RQ4 RQ11
            cc_pulldown_en <= !is_src_side(state_next); // RQ7 RQ11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst)
            adv_reg <= ADV_RESET; // RQ12
        else if (adv_wr && i2c_mode && adv_level != CUR_NONE)
            adv_reg <= adv_level; // RQ5 RQ12
    end

    always_ff @(posedge clk_sys) begin
        if (srst)
            cc_rp_level <= ADV_RESET;
        else
            cc_rp_level <= i2c_mode ? adv_reg : CUR_DEF; // RQ5 RQ6
    end

    ////////////////////////////////////////////////////////////////////
    // detected current and status

    assign cap_evt = state_next == ST_ASNK && state_reg != ST_ASNK;
    // refresh only while attached: the partner's Rp is then on the line
    assign refresh_evt = soft_reset && state_reg == ST_ASNK && !cap_evt;
    assign status_evt = is_attached(state_next) != attached ||
                        cap_evt || refresh_evt;

    always_ff @(posedge clk_sys) begin
        if (srst)
            cur_detect <= CUR_NONE;
        else if (cap_evt || refresh_evt)
            cur_detect <= sink_cur(cc1_sense, cc2_sense); // RQ9 RQ10
        else if (state_next != ST_ASNK)
            cur_detect <= CUR_NONE;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            attached <= 1'b0;
            audio_det <= 1'b0;
            debug_det <= 1'b0;
        end else begin
            attached <= is_attached(state_next);
            audio_det <= state_next == ST_AUDIO; // RQ13
            debug_det <= state_next == ST_DEBUG; // RQ13
        end
    end

    // a new event outranks a clear landing in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst)
            int_status <= 1'b0;
        else if (status_evt)
            int_status <= 1'b1; // RQ20
        else if (int_clear)
            int_status <= 1'b0; // RQ20
    end

    ////////////////////////////////////////////////////////////////////
    // open-drain pins: only enables leave the block, level is always low

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            current_code_out_a_oe <= 1'b0;
            current_code_out_b_oe <= 1'b0;
            audio_accessory_out_oe <= 1'b0;
        end else if (i2c_mode) begin
            current_code_out_a_oe <= 1'b0; // RQ22
            current_code_out_b_oe <= 1'b0; // RQ22
            audio_accessory_out_oe <= int_status; // RQ18 RQ20
        end else begin
            audio_accessory_out_oe <= audio_det; // RQ15 RQ18
            case (state_reg)
                ST_ASNK: begin
                    {current_code_out_a_oe, current_code_out_b_oe} <=
                        gpio_code(cur_detect); // RQ19
                end
                ST_ASRC, ST_AUDIO, ST_DEBUG: begin
                    {current_code_out_a_oe, current_code_out_b_oe} <=
                        gpio_code(CUR_DEF); // RQ19
                end
                default: begin
                    current_code_out_a_oe <= 1'b0;
                    current_code_out_b_oe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence snk_ready_s;
        state_reg == ST_WSNK && rp_seen && cc_settled && vbus_ok;
    endsequence

    sequence src_audio_s;
        state_reg == ST_WSRC && ra_both && cc_settled;
    endsequence

    strap_decode_a: assert property ( // RQ1
        $rose(role_loaded_reg) |-> role_out == role_of(port_code))
        else $error("role does not follow the role strap");

    strap_hold_a: assert property ( // RQ2
        role_loaded_reg && !mode_sel_wr |=> $stable(role_out))
        else $error("role moved without a select write");

    src_select_a: assert property ( // RQ3
        mode_sel_wr && i2c_mode && unatt && role_loaded_reg &&
        mode_sel_role == ROLE_SRC |=> role_out == ROLE_SRC)
        else $error("source select write not taken");

    src_pullup_a: assert property ( // RQ4
        is_src_side(state_reg) |-> cc_pullup_en && !cc_pulldown_en)
        else $error("source state without pull-ups");

    adv_follow_a: assert property ( // RQ5
        adv_wr && i2c_mode && adv_level != CUR_NONE ##1 !adv_wr
        |=> cc_rp_level == $past(adv_level, 2))
        else $error("pull-up level did not follow the write");

    gpio_default_a: assert property ( // RQ6
        !i2c_mode && $past(!i2c_mode) |-> cc_rp_level == CUR_DEF)
        else $error("GPIO style advertised above default");

    snk_pulldown_a: assert property ( // RQ7
        !is_src_side(state_reg) |-> cc_pulldown_en && !cc_pullup_en)
        else $error("sink state without pull-downs");

    snk_attach_a: assert property ( // RQ8
        snk_ready_s |=> state_reg == ST_ASNK)
        else $error("sink did not attach when ready");

    vbus_gate_a: assert property ( // RQ8
        $rose(state_reg == ST_ASNK) |-> $past(vbus_ok) && $past(cc_settled))
        else $error("sink attached without vbus or debounce");

    cur_capture_a: assert property ( // RQ9
        $rose(state_reg == ST_ASNK) |->
        cur_detect == $past(sink_cur(cc1_sense, cc2_sense)))
        else $error("detected current not captured on attach");

    drp_toggle_a: assert property ( // RQ11
        state_reg == ST_UNSNK && role_out == ROLE_DRP && drp_src_phase &&
        !rp_seen |=> state_reg == ST_UNSRC)
        else $error("dual-role did not switch to source");

    audio_entry_a: assert property ( // RQ14
        src_audio_s |=> state_reg == ST_AUDIO && audio_det)
        else $error("audio adapter not recognised");

    audio_pattern_a: assert property ( // RQ14
        state_reg == ST_AUDIO |-> $past(ra_both))
        else $error("audio state without Ra on both lines");

    audio_pin_a: assert property ( // RQ15
        !i2c_mode && $past(!i2c_mode) |->
        audio_accessory_out_oe == $past(audio_det))
        else $error("audio pin does not show the accessory");

    debug_block_a: assert property ( // RQ16
        $rose(state_reg == ST_DEBUG) |->
        $past(role_out == ROLE_SRC || !vbus_ok))
        else $error("charge-through debug accessory accepted");

    ctrl_decode_a: assert property ( // RQ17
        $rose(role_loaded_reg) |-> i2c_mode == (ctrl_code != STRAP_FLOAT))
        else $error("control style does not follow the strap");

    gpio_code_a: assert property ( // RQ19
        !i2c_mode && $past(!i2c_mode) && $past(state_reg == ST_ASNK) |->
        {current_code_out_a_oe, current_code_out_b_oe} ==
        gpio_code($past(cur_detect)))
        else $error("current pins carry the wrong code");

    int_sticky_a: assert property ( // RQ20
        status_evt ##1 (!status_evt && !int_clear) [*2] |-> int_status [*2])
        else $error("interrupt status lost before a clear");

    int_clear_a: assert property ( // RQ20
        int_clear && !status_evt |=> !int_status)
        else $error("interrupt status not cleared");

    role_lock_a: assert property ( // RQ21
        mode_sel_wr && !unatt |=> $stable(role_out))
        else $error("role changed while attached");

    i2c_pins_a: assert property ( // RQ22
        i2c_mode && $past(i2c_mode) |->
        !current_code_out_a_oe && !current_code_out_b_oe)
        else $error("current pins driven in I2C style");
endmodule
`default_nettype wire

// file: bench/tcprc_partner.sv
// port partner model: source, sink or audio adapter on the CC lines
`timescale 1ns/1ps
`default_nettype none
module tcprc_partner (
    input wire logic cc_pullup_en,
    input wire logic cc_pulldown_en,
    input wire logic [1:0] pmode,
    input wire tcprc_pkg::tcprc_cur_t plevel,
    output var tcprc_pkg::tcprc_cc_t cc1_sense,
    output var tcprc_pkg::tcprc_cc_t cc2_sense,
    output logic vbus_det
);
    import tcprc_pkg::*;
    // pmode: 1 source, 2 sink, 3 audio adapter, 0 nothing attached
    always_comb begin
        cc1_sense = CC_OPEN;
        cc2_sense = CC_OPEN;
        // a source powers vbus only while it sees our pull-down
        vbus_det = pmode == 2'h1 && cc_pulldown_en;
        if (pmode == 2'h1 && cc_pulldown_en) begin
            cc1_sense = tcprc_cc_t'(3'(plevel) + 3'h2);
        end
        // a sink with no level stands for a debug accessory, Rd on both
        if (pmode == 2'h2 && cc_pullup_en) begin
            cc1_sense = plevel == CUR_NONE ? CC_RD : CC_OPEN;
            cc2_sense = CC_RD;
        end
        if (pmode == 2'h3 && cc_pullup_en) begin
            cc1_sense = CC_RA;
            cc2_sense = CC_RA;
        end
    end
endmodule
`default_nettype wire

// file: bench/tcprc_port_ctrl_tb.sv
// self-checking bench for the port role and current block
`timescale 1ns/1ps
`default_nettype none
module tcprc_port_ctrl_tb;
    import tcprc_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ph = 1'b0, pl = 1'b0, ah = 1'b0, al = 1'b0;
    logic msw = 1'b0, aw = 1'b0, take = 1'b0;
    logic sr = 1'b0, ic = 1'b0, i2c, dbg, ist;
    tcprc_role_t msr = ROLE_SRC;
    tcprc_cur_t al_v = CUR_DEF, lvl = CUR_DEF;
    logic [1:0] pmode = 2'h0;
    tcprc_cc_t cc1, cc2;
    tcprc_role_t role;
    tcprc_cur_t rp, cur;
    logic vb, pu, pd, oa, ob, oc, att, aud;
    logic [15:0] exp_w;
    logic [15:0] exp_q[$];
    int failures = 0;
    int n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    tcprc_port_ctrl #(.CC_DB_CYCLES(8), .VBUS_DB_CYCLES(4),
        .DRP_CYCLES(40), .DRP_SRC_CYCLES(12)) u_tcprc_port_ctrl (
        .clk_sys(clk_sys), .srst(srst), .port_strap_high(ph),
        .port_strap_low(pl), .addr_strap_high(ah), .addr_strap_low(al),
        .cc1_sense(cc1), .cc2_sense(cc2), .vbus_det(vb),
        .mode_sel_wr(msw), .mode_sel_role(msr), .adv_wr(aw),
        .adv_level(al_v), .soft_reset(sr), .int_clear(ic),
        .cc_pullup_en(pu), .cc_pulldown_en(pd), .cc_rp_level(rp),
        .current_code_out_a_oe(oa), .current_code_out_b_oe(ob),
        .audio_accessory_out_oe(oc), .role_out(role), .i2c_mode(i2c),
        .attached(att), .cur_detect(cur), .audio_det(aud),
        .debug_det(dbg), .int_status(ist));
    tcprc_partner u_tcprc_partner (.cc_pullup_en(pu), .cc_pulldown_en(pd),
        .pmode(pmode), .plevel(lvl), .cc1_sense(cc1), .cc2_sense(cc2),
        .vbus_det(vb));
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (take) begin
            exp_w = exp_q.pop_front();
            n_compared++;
            if ({pu, pd, rp, oa, ob, role, att, cur, aud, oc, i2c, dbg,
                ist} !== exp_w) begin
                failures++;
                $display("mismatch at %0t: want %h", $time, exp_w);
            end
        end
    end
    task automatic complete_run;
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] e);
        exp_q.push_back(e);
        take <= 1'b1;
        @(posedge clk_sys);
        take <= 1'b0;
    endtask
    task automatic wait_att(input logic v);
        int i;
        for (i = 0; i < 400 && att !== v; i++) @(posedge clk_sys);
        if (i == 400) begin
            $display("mismatch at %0t: attach wait ran out", $time);
            failures++;
            complete_run();
        end
        // gpio pins trail the state by one edge
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic rst(input logic h, l, a_h, a_l);
        srst <= 1'b1;
        pmode <= 2'h0;
        {ph, pl, ah, al} <= {h, l, a_h, a_l};
        repeat (15) @(posedge clk_sys);
        check({4'h5, 2'h0, ROLE_SNK, 1'b0, CUR_NONE, 2'h0, 3'h0});
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic pulse_mode(input tcprc_role_t r);
        msr <= r;
        msw <= 1'b1;
        @(posedge clk_sys);
        msw <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(83903));
        // three sink-only levels, then dual-role at a random level
        for (int i = 0; i < 4; i++) begin
            lvl <= (i < 3) ? tcprc_cur_t'(2'(i + 1))
                : tcprc_cur_t'(2'($urandom_range(3, 1)));
            rst(1'b0, i < 3, 1'b0, 1'b0);
            pmode <= 2'h1;
            wait_att(1'b1);
            check({2'h1, CUR_DEF, lvl, (i < 3) ? ROLE_SNK : ROLE_DRP,
                1'b1, lvl, 2'h0, 3'h1});
            pmode <= 2'h0;
            wait_att(1'b0);
        end
        // bus-style sink: status clear, then a refresh picks up a new level
        rst(1'b0, 1'b1, 1'b1, 1'b0);
        lvl <= CUR_DEF;
        pmode <= 2'h1;
        wait_att(1'b1);
        ic <= 1'b1;
        @(posedge clk_sys);
        ic <= 1'b0;
        lvl <= CUR_HIGH;
        repeat (2) @(posedge clk_sys);
        check({4'h5, 2'h0, ROLE_SNK, 1'b1, CUR_DEF, 2'h0, 3'h4});
        sr <= 1'b1;
        @(posedge clk_sys);
        sr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check({4'h5, 2'h0, ROLE_SNK, 1'b1, CUR_HIGH, 2'h1, 3'h5});
        // sink strap in bus style, overridden to source while unattached
        rst(1'b0, 1'b1, 1'b0, 1'b1);
        pulse_mode(ROLE_SRC);
        al_v <= tcprc_cur_t'(2'($urandom_range(3, 1)));
        aw <= 1'b1;
        @(posedge clk_sys);
        aw <= 1'b0;
        pmode <= 2'h2;
        wait_att(1'b1);
        pulse_mode(ROLE_SNK);
        repeat (2) @(posedge clk_sys);
        check({2'h2, al_v, 2'h0, ROLE_SRC, 1'b1, CUR_NONE, 2'h1, 3'h5});
        // gpio source ignores advertise writes, then an audio adapter
        rst(1'b1, 1'b0, 1'b0, 1'b0);
        al_v <= CUR_HIGH;
        aw <= 1'b1;
        @(posedge clk_sys);
        aw <= 1'b0;
        pmode <= 2'h3;
        wait_att(1'b1);
        check({2'h2, CUR_DEF, 2'h1, ROLE_SRC, 1'b1, CUR_NONE, 2'h3,
            3'h1});
        // then a debug accessory, accepted by a source without vbus
        pmode <= 2'h0;
        wait_att(1'b0);
        lvl <= CUR_NONE;
        pmode <= 2'h2;
        wait_att(1'b1);
        check({2'h2, CUR_DEF, 2'h1, ROLE_SRC, 1'b1, CUR_NONE, 2'h0,
            3'h3});
        repeat (2) @(posedge clk_sys);
        complete_run();
    end
endmodule
`default_nettype wire
